// ===== hdl/shs_pkg.sv
// Constants, states and carriers shared by the standby controller files
package shs_pkg;
  localparam logic [15:0] SETTLE_ADDR     = 16'hfffa;
  localparam int          SEL_W           = 3;
  localparam int          DATA_W          = 8;
  localparam logic [2:0]  SETTLE_RST_VAL  = 3'h4;
  localparam logic [2:0]  SEL_SHORT       = 3'h0;
  localparam logic [2:0]  SEL_MID         = 3'h2;
  localparam int          SHORT_EXP       = 12;
  localparam int          MID_EXP         = 15;
  localparam int          LONG_EXP        = 17;
  localparam int          SETTLE_SHORT_CYC = 1 << SHORT_EXP;
  localparam int          SETTLE_MID_CYC  = 1 << MID_EXP;
  localparam int          SETTLE_LONG_CYC = 1 << LONG_EXP;
  localparam int          CNT_W           = 18;
  localparam int          WAKE_W          = 4;
  localparam int          WAKE_VEC_CYC    = 9;
  localparam int          WAKE_DIRECT_CYC = 1;
  localparam int          NUM_INT         = 8;
  localparam int          SYNC_W          = 2;
  localparam logic [1:0]  SYNC_RST_VAL    = 2'h0;
  localparam logic        OSC_EN_RST      = 1'h1;
  localparam logic        RST_PEND_RST    = 1'h1;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_HALT     = 3'b001,
    ST_STOP     = 3'b010,
    ST_OSC_WAIT = 3'b011,
    ST_SETTLE   = 3'b100,
    ST_WAKE     = 3'b101,
    ST_RESET    = 3'b110
  } shs_state_type;

  typedef struct packed {
    logic sub_clk_running;
    logic wide_sub_sel;
    logic buzzer_en;
    logic wide_main_sel;
    logic ext_count_pin_a_sel;
    logic ext_count_pin_b_sel;
    logic timer_c_main_sel;
    logic timer_c_sub_sel;
    logic watch_main_sel;
    logic watch_sub_sel;
    logic serial_ext_clk;
  } shs_periph_cfg_type;

  typedef struct packed {
    logic wide_timer;
    logic byte_timer_a;
    logic byte_timer_b;
    logic byte_timer_c;
    logic watch_timer;
    logic watchdog;
    logic serial;
    logic two_wire_bus_unit;
    logic bus_addr_wake;
    logic adc;
    logic multiplier;
    logic ext_int;
  } shs_periph_run_type;

  function automatic logic [CNT_W-1:0] settle_target(input logic [2:0] code,
      input logic after_rst, input int mid_cyc, input int long_cyc);
    if (after_rst) return CNT_W'(mid_cyc);
    else if (code == SEL_SHORT) return CNT_W'(SETTLE_SHORT_CYC);
    else if (code == SEL_MID) return CNT_W'(mid_cyc);
    else return CNT_W'(long_cyc);
  endfunction : settle_target
endpackage : shs_pkg

// ===== hdl/shs_settle_cnt.sv
// Oscillation settle counter with selectable power-of-two length
`timescale 1ns/1ps
module shs_settle_cnt
  import shs_pkg::*;
#(
  parameter int MID_CYC  = SETTLE_MID_CYC,
  parameter int LONG_CYC = SETTLE_LONG_CYC
)(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             restart,
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic             after_rst,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] target_reg;

  // Target is frozen at restart so a late write cannot stretch the wait
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg    <= '0;
      target_reg <= CNT_W'(MID_CYC);
      done       <= 1'b0;
    end else if (restart) begin
      cnt_reg    <= '0;
      target_reg <= settle_target(sel, after_rst, MID_CYC, LONG_CYC);
      done       <= 1'b0;
    end else if (!done) begin
      cnt_reg <= cnt_reg + 1'b1;
      if (cnt_reg == target_reg - 1'b1) done <= 1'b1;
    end
  end

  settle_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(done) |-> $past(cnt_reg) == target_reg - 1'b1 && !$past(restart))
    else $error("settle wait ended at wrong count");
endmodule : shs_settle_cnt

// ===== hdl/shs_standby_ctrl.sv
// Standby controller: halt, stop, settle wait and peripheral run gating
//
// Overview of operation
// - Halt gates CPU clock, oscillator keeps running
// - Stop shuts main oscillator, halting all main-clocked logic
// - Standby keeps registers, memory and port states
// - Select codes 000/010/100 give 2^12/2^15/2^17 waits
// - Reset loads 04H yet waits 2^15
// - Wait counts from oscillator start only
// - Unmasked request ends halt; IE picks vector
// - Resume 9-10 clocks vectored, 1-2 direct
// - Non-maskable request ends halt, always vectored
// - Reset during halt restarts from reset vector
// - Pending unmasked request at entry leaves halt at once, stop after settle wait
// - Stop: timer A counts only from pin
// - Stop: timer B counts only from pin
// - Stop: serial runs only on external clock
// - Stop: bus unit still wakes on address match
// - Stop: wide timer needs subclock and buzzer
// - Halt without subclock: main-clocked timers only
// - Stop disables watchdog, converter and multiplier
// - External interrupts stay live; unmasked ones wake
// - Unmasked request leaves stop after settle wait
// - Reset in stop acts after settle wait
`timescale 1ns/1ps
module shs_standby_ctrl
  import shs_pkg::*;
#(
  parameter int SETTLE_MID  = SETTLE_MID_CYC,
  parameter int SETTLE_LONG = SETTLE_LONG_CYC
)(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               reset_pin_n,
  input  wire logic               osc_running,
  input  wire logic [15:0]        cpu_addr,
  input  wire logic               cpu_wr_en,
  input  wire logic               cpu_wr_byte,
  input  wire logic [DATA_W-1:0]  cpu_wdata,
  input  wire logic               cpu_rd_en,
  output logic      [DATA_W-1:0]  cpu_rdata,
  input  wire logic               halt_exec,
  input  wire logic               stop_exec,
  input  wire logic [NUM_INT-1:0] int_req,
  input  wire logic [NUM_INT-1:0] source_mask_flag,
  input  wire logic               global_int_allow_flag,
  input  wire logic               nmi_req,
  input  wire shs_periph_cfg_type periph_cfg,
  output logic                    cpu_clk_en,
  output logic                    osc_enable,
  output logic                    cpu_reset_out,
  output logic                    cpu_resume,
  output logic                    cpu_vector,
  output logic                    port_hold,
  output shs_periph_run_type      periph_run
);
  shs_state_type      state_reg;
  shs_state_type      state_next;
  logic [SEL_W-1:0]   osc_settle_select_reg;
  logic [SYNC_W-1:0]  pin_sync;
  logic               rst_ok;
  logic               osc_ok;
  logic               settle_done;
  logic               settle_restart;
  logic               rst_pend_reg;
  logic               wake_vec_reg;
  logic               wake_vec_next;
  logic [WAKE_W-1:0]  wake_cnt_reg;
  logic [NUM_INT-1:0] wake_src;
  logic               wake_any;
  logic               leaving_idle;
  logic               osc_en_next;
  shs_periph_run_type run_next;

  // Reset pin and oscillator status come from outside this clock
  shs_sync3 u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({reset_pin_n, osc_running}),
    .sync_out (pin_sync)
  );
  assign rst_ok = pin_sync[1];
  assign osc_ok = pin_sync[0];

  shs_settle_cnt #(
    .MID_CYC  (SETTLE_MID),
    .LONG_CYC (SETTLE_LONG)
  ) u_settle (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .restart   (settle_restart),
    .sel       (osc_settle_select_reg),
    .after_rst (rst_pend_reg),
    .done      (settle_done)
  );

  // Only unmasked requests are wake sources
  assign wake_src = int_req & ~source_mask_flag;
  assign wake_any = |wake_src;

  // Vector decision taken at the moment of release
  assign wake_vec_next = (state_reg == ST_HALT && nmi_req) ||
                         (wake_any && global_int_allow_flag);

  assign leaving_idle = (state_reg == ST_RUN || state_reg == ST_HALT ||
                         state_reg == ST_STOP) && state_next != state_reg;

  assign settle_restart = state_next == ST_SETTLE && state_reg != ST_SETTLE;

  always_comb begin
    state_next = state_reg;
    if (!rst_ok) begin
      state_next = ST_RESET;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (halt_exec) state_next = ST_HALT;
          else if (stop_exec && wake_any) state_next = ST_SETTLE;
          else if (stop_exec) state_next = ST_STOP;
        end
        ST_HALT: begin
          if (nmi_req || wake_any) state_next = ST_WAKE;
        end
        ST_STOP: begin
          if (wake_any) state_next = ST_OSC_WAIT;
        end
        ST_OSC_WAIT: begin
          if (osc_ok) state_next = ST_SETTLE;
        end
        ST_SETTLE: begin
          if (settle_done && rst_pend_reg) state_next = ST_RUN;
          else if (settle_done) state_next = ST_WAKE;
        end
        ST_WAKE: begin
          if (wake_cnt_reg == '0) state_next = ST_RUN;
        end
        ST_RESET: begin
          state_next = ST_OSC_WAIT;
        end
        default: begin
          state_next = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) state_reg <= ST_OSC_WAIT;
    else state_reg <= state_next;
  end

  // Settle select register; reset input also reloads it
  always_ff @(posedge clk) begin
    if (sys_rst || !rst_ok) begin
      osc_settle_select_reg <= SETTLE_RST_VAL;
    end else if (cpu_wr_en && cpu_wr_byte && cpu_addr == SETTLE_ADDR) begin
      osc_settle_select_reg <= cpu_wdata[SEL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_rdata <= '0;
    end else if (cpu_rd_en && cpu_addr == SETTLE_ADDR) begin
      cpu_rdata <= {{(DATA_W-SEL_W){1'b0}}, osc_settle_select_reg};
    end else begin
      cpu_rdata <= '0;
    end
  end

  // Reset sequence pending until the settle wait ends
  always_ff @(posedge clk) begin
    if (sys_rst) rst_pend_reg <= RST_PEND_RST;
    else if (state_next == ST_RESET) rst_pend_reg <= 1'b1;
    else if (state_reg == ST_SETTLE && settle_done) rst_pend_reg <= 1'b0;
  end
  assign cpu_reset_out = rst_pend_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) wake_vec_reg <= 1'b0;
    else if (leaving_idle) wake_vec_reg <= wake_vec_next;
  end

  // Resume delay counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_cnt_reg <= '0;
    end else if (state_next == ST_WAKE && state_reg != ST_WAKE) begin
      if ((state_reg == ST_HALT) ? wake_vec_next : wake_vec_reg)
        wake_cnt_reg <= WAKE_W'(WAKE_VEC_CYC - 1);
      else
        wake_cnt_reg <= WAKE_W'(WAKE_DIRECT_CYC - 1);
    end else if (state_reg == ST_WAKE && wake_cnt_reg != '0) begin
      wake_cnt_reg <= wake_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_resume <= 1'b0;
      cpu_vector <= 1'b0;
    end else begin
      cpu_resume <= state_reg == ST_WAKE && state_next == ST_RUN;
      cpu_vector <= state_reg == ST_WAKE && state_next == ST_RUN && wake_vec_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) cpu_clk_en <= 1'b0;
    else cpu_clk_en <= state_next == ST_RUN;
  end

  // Oscillator stays off across a reset that arrives during stop
  always_comb begin
    case (state_next)
      ST_STOP:  osc_en_next = 1'b0;
      ST_RESET: osc_en_next = osc_enable;
      default:  osc_en_next = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) osc_enable <= OSC_EN_RST;
    else osc_enable <= osc_en_next;
  end

  // Ports and state are held in standby but not through reset
  always_ff @(posedge clk) begin
    if (sys_rst) port_hold <= 1'b0;
    else port_hold <= state_next != ST_RUN && state_next != ST_RESET &&
                      !rst_pend_reg;
  end

  // Peripheral run enables per operating state
  always_comb begin
    run_next = '1;
    case (state_next)
      ST_HALT, ST_SETTLE, ST_WAKE: begin
        run_next.wide_timer   = periph_cfg.sub_clk_running ||
                                periph_cfg.wide_main_sel;
        run_next.byte_timer_c = periph_cfg.sub_clk_running ||
                                periph_cfg.timer_c_main_sel;
        run_next.watch_timer  = periph_cfg.sub_clk_running ||
                                periph_cfg.watch_main_sel;
        run_next.bus_addr_wake = 1'b0;
        run_next.adc          = 1'b0;
        run_next.multiplier   = 1'b0;
      end
      ST_STOP, ST_OSC_WAIT: begin
        run_next.wide_timer   = periph_cfg.sub_clk_running &&
                                periph_cfg.wide_sub_sel &&
                                periph_cfg.buzzer_en;
        run_next.byte_timer_a = periph_cfg.ext_count_pin_a_sel;
        run_next.byte_timer_b = periph_cfg.ext_count_pin_b_sel;
        run_next.byte_timer_c = periph_cfg.sub_clk_running &&
                                periph_cfg.timer_c_sub_sel;
        run_next.watch_timer  = periph_cfg.sub_clk_running &&
                                periph_cfg.watch_sub_sel;
        run_next.serial       = periph_cfg.serial_ext_clk;
        run_next.bus_addr_wake = 1'b1;
        run_next.watchdog     = 1'b0;
        run_next.adc          = 1'b0;
        run_next.multiplier   = 1'b0;
      end
      ST_RESET: begin
        run_next = '0;
      end
      default: begin
        run_next.bus_addr_wake = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) periph_run <= '0;
    else periph_run <= run_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  halt_clock_gate_a: assert property (
    state_reg == ST_HALT |-> !cpu_clk_en && osc_enable)
    else $error("cpu clock running in halt");

  stop_osc_off_a: assert property (
    state_reg == ST_RUN && rst_ok && !halt_exec && stop_exec && !wake_any
    |=> !osc_enable && !cpu_clk_en)
    else $error("oscillator not stopped by stop");

  standby_hold_a: assert property (
    (state_reg == ST_HALT || state_reg == ST_STOP) && !rst_pend_reg |-> port_hold)
    else $error("ports not held in standby");

  reset_reload_a: assert property (
    !rst_ok |=> osc_settle_select_reg == SETTLE_RST_VAL && cpu_reset_out)
    else $error("reset did not reload select register");

  osc_wait_a: assert property (
    state_reg == ST_OSC_WAIT && !osc_ok |=> state_reg != ST_SETTLE)
    else $error("settle wait began before oscillator ran");

  masked_stays_a: assert property (
    state_reg == ST_HALT && rst_ok && !nmi_req && !wake_any |=> state_reg == ST_HALT)
    else $error("masked request left halt");

  vec_resume_a: assert property (
    state_reg == ST_HALT && rst_ok && wake_any && global_int_allow_flag
    ##1 rst_ok [*8] ##1 rst_ok |-> ##[0:1] cpu_resume && cpu_vector)
    else $error("vectored resume outside 9 to 10 clocks");

  direct_resume_a: assert property (
    state_reg == ST_HALT && rst_ok && wake_any && !global_int_allow_flag && !nmi_req
    ##1 rst_ok [*2] |-> cpu_resume && !cpu_vector)
    else $error("direct resume outside 1 to 2 clocks");

  nmi_wake_a: assert property (
    state_reg == ST_HALT && rst_ok && nmi_req |=> state_reg == ST_WAKE && wake_vec_reg)
    else $error("nmi did not force vectored wake");

  stop_pending_a: assert property (
    state_reg == ST_RUN && rst_ok && stop_exec && !halt_exec && wake_any
    |=> state_reg == ST_SETTLE && osc_enable)
    else $error("pending request did not skip stop");

  stop_periph_a: assert property (
    state_reg == ST_STOP |-> !periph_run.watchdog && !periph_run.adc &&
    !periph_run.multiplier && periph_run.ext_int)
    else $error("forbidden unit running in stop");

  reset_first_a: assert property (
    !rst_ok && nmi_req |=> state_reg == ST_RESET && cpu_reset_out && !cpu_clk_en)
    else $error("release source beat reset");

  settle_reset_a: assert property (
    state_reg == ST_SETTLE && rst_pend_reg && !settle_done && rst_ok
    |=> cpu_reset_out)
    else $error("reset released before settle end");
endmodule : shs_standby_ctrl

// ===== hdl/shs_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module shs_sync3
  import shs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg <= SYNC_RST_VAL;
      s2_reg <= SYNC_RST_VAL;
      s3_reg <= SYNC_RST_VAL;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_out <= SYNC_RST_VAL;
    end else begin
      for (int i = 0; i < SYNC_W; i++) begin
        if (s2_reg[i] == s3_reg[i]) sync_out[i] <= s3_reg[i];
      end
    end
  end
endmodule : shs_sync3

// ===== test/shs_osc_model.sv
// Main oscillator model: runs a set number of cycles after it is enabled
`timescale 1ns/1ps
module shs_osc_model (
  input  wire logic        clk,
  input  wire logic        osc_enable,
  input  wire logic [15:0] start_dly,
  output logic             osc_running
);
  logic [15:0] wait_reg;

  initial begin
    osc_running = 1'b0;
    wait_reg    = 16'h0000;
  end

  // Running status only comes up once the start-up delay has passed
  always @(posedge clk) begin
    if (osc_enable !== 1'b1) begin
      wait_reg    <= 16'h0000;
      osc_running <= 1'b0;
    end else if (wait_reg < start_dly) begin
      wait_reg <= wait_reg + 16'h0001;
    end else begin
      osc_running <= 1'b1;
    end
  end
endmodule : shs_osc_model

// ===== test/tb_standby_halt_stop_control.sv
// Self-checking bench for the standby controller
`timescale 1ns/1ps
`define chk(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
`define await(cond, lim) begin int n_w; n_w = 0; \
  while (!(cond) && n_w < lim) begin @(posedge clk); n_w++; end end
module tb_standby_halt_stop_control;
  import shs_pkg::*;
  typedef struct packed {logic kind; logic [7:0] val; int lo; int hi;} shs_note_type;
  logic               clk, sys_rst, reset_pin_n, osc_running, cpu_wr_en, cpu_wr_byte;
  logic [15:0]        cpu_addr, start_dly;
  logic [7:0]         cpu_wdata, cpu_rdata, int_req, source_mask_flag;
  logic               cpu_rd_en, halt_exec, stop_exec, global_int_allow_flag, nmi_req;
  logic               cpu_clk_en, osc_enable, cpu_reset_out, cpu_resume, cpu_vector, port_hold;
  logic               rd_d;
  shs_periph_cfg_type periph_cfg;
  shs_periph_run_type periph_run;
  shs_note_type       note_q[$];
  shs_note_type       note_v;
  int                 num_errors, cmp_count, cyc;

  shs_standby_ctrl #(.SETTLE_MID(64), .SETTLE_LONG(128)) shs_standby_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .osc_running(osc_running),
    .cpu_addr(cpu_addr), .cpu_wr_en(cpu_wr_en), .cpu_wr_byte(cpu_wr_byte),
    .cpu_wdata(cpu_wdata), .cpu_rd_en(cpu_rd_en), .cpu_rdata(cpu_rdata),
    .halt_exec(halt_exec), .stop_exec(stop_exec), .int_req(int_req),
    .source_mask_flag(source_mask_flag), .global_int_allow_flag(global_int_allow_flag),
    .nmi_req(nmi_req), .periph_cfg(periph_cfg), .cpu_clk_en(cpu_clk_en),
    .osc_enable(osc_enable), .cpu_reset_out(cpu_reset_out), .cpu_resume(cpu_resume),
    .cpu_vector(cpu_vector), .port_hold(port_hold), .periph_run(periph_run));

  shs_osc_model shs_osc_model_inst (.clk(clk), .osc_enable(osc_enable),
    .start_dly(start_dly), .osc_running(osc_running));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Takes the oldest note whenever read data or a resume pulse shows
  always @(posedge clk) begin
    if (rd_d === 1'b1 || cpu_resume === 1'b1) begin
      if (note_q.size() == 0) begin
        `chk(cpu_resume, 1'b0)
      end else begin
        note_v = note_q.pop_front();
        if (note_v.kind) begin
          `chk(cpu_vector, note_v.val[0])
          `chk(1'(cyc >= note_v.lo && cyc <= note_v.hi), 1'b1)
        end else begin
          `chk(cpu_rdata, note_v.val)
        end
      end
    end
    rd_d <= cpu_rd_en;
    cyc  <= cyc + 1;
  end

  task automatic end_sim;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic byt);
    @(posedge clk);
    cpu_addr    <= a;
    cpu_wdata   <= d;
    cpu_wr_byte <= byt;
    cpu_wr_en   <= 1'b1;
    @(posedge clk);
    cpu_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    cpu_addr  <= a;
    cpu_rd_en <= 1'b1;
    note_q.push_back('{1'b0, e, 0, 0});
    @(posedge clk);
    cpu_rd_en <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Halt, show masked requests, then wake by request or non-maskable request
  task automatic halt_wake(input logic ie, input logic nmi);
    logic [7:0] src;
    int         t0;
    src = 8'h01 << ($urandom % 8);
    @(posedge clk);
    periph_cfg            <= shs_periph_cfg_type'(11'($urandom));
    halt_exec             <= 1'b1;
    global_int_allow_flag <= ie;
    source_mask_flag      <= ~src;
    @(posedge clk);
    halt_exec <= 1'b0;
    int_req   <= ~src;
    repeat (4) @(posedge clk);
    `chk({cpu_clk_en, osc_enable, port_hold}, 3'b011)
    `chk({periph_run.adc, periph_run.multiplier}, 2'b00)
    if (!periph_cfg.sub_clk_running) begin
      `chk({periph_run.wide_timer, periph_run.byte_timer_c, periph_run.watch_timer}, {periph_cfg.wide_main_sel, periph_cfg.timer_c_main_sel, periph_cfg.watch_main_sel})
    end
    @(posedge clk);
    t0 = cyc;
    note_q.push_back('{1'b1, {7'h0, ie | nmi}, t0 + ((ie | nmi) ? 11 : 3), t0 + ((ie | nmi) ? 12 : 4)});
    if (nmi) nmi_req <= 1'b1;
    else int_req <= int_req | src;
    `await(note_q.size() == 0, 40)
    `chk(note_q.size(), 0)
    `chk(cpu_clk_en, 1'b1)
    int_req <= 8'h00;
    nmi_req <= 1'b0;
  endtask : halt_wake

  // Stop with a chosen settle code; pend leaves an unmasked request at entry
  task automatic stop_wake(input logic [2:0] code, input logic pend);
    int n, d, t0;
    n = (code == 3'h0) ? 4096 : (code == 3'h2) ? 64 : 128;
    d = 40 + $urandom % 160;
    wr(SETTLE_ADDR, {5'h00, code}, 1'b1);
    @(posedge clk);
    start_dly             <= 16'(d);
    periph_cfg            <= shs_periph_cfg_type'(11'($urandom));
    stop_exec             <= 1'b1;
    global_int_allow_flag <= 1'b1;
    source_mask_flag      <= 8'hfe;
    int_req               <= {7'h00, pend};
    t0 = cyc;
    @(posedge clk);
    stop_exec <= 1'b0;
    @(posedge clk);
    `chk(osc_enable, pend)
    if (!pend) begin
      @(posedge clk);
      `chk({periph_run.watchdog, periph_run.adc, periph_run.multiplier}, 3'b000)
      `chk(periph_run.bus_addr_wake, 1'b1)
      `chk(periph_run.ext_int, 1'b1)
      `chk(periph_run.byte_timer_a, periph_cfg.ext_count_pin_a_sel)
      `chk(periph_run.byte_timer_b, periph_cfg.ext_count_pin_b_sel)
      `chk(periph_run.serial, periph_cfg.serial_ext_clk)
      `chk(periph_run.wide_timer, periph_cfg.sub_clk_running & periph_cfg.wide_sub_sel & periph_cfg.buzzer_en)
      `chk(cpu_clk_en, 1'b0)
      repeat (4) @(posedge clk);
      t0 = cyc;
      int_req <= 8'h03;
    end
    note_q.push_back('{1'b1, 8'h01, t0 + (pend ? 0 : d) + n, t0 + (pend ? 0 : d) + n + 30});
    `await(note_q.size() == 0, n + d + 60)
    `chk(note_q.size(), 0)
    int_req <= 8'h00;
  endtask : stop_wake

  // Reset pin pulled low in halt or stop; checks the settle before release
  task automatic pin_reset(input logic in_stop, input int d);
    int t0;
    wr(SETTLE_ADDR, 8'h00, 1'b1);
    @(posedge clk);
    start_dly        <= 16'(d);
    source_mask_flag <= 8'hff;
    halt_exec        <= !in_stop;
    stop_exec        <= in_stop;
    @(posedge clk);
    halt_exec   <= 1'b0;
    stop_exec   <= 1'b0;
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    `chk({cpu_reset_out, cpu_clk_en}, 2'b10)
    if (in_stop) `chk(osc_enable, 1'b0)
    nmi_req <= 1'b1;
    wr(SETTLE_ADDR, 8'h02, 1'b1);
    rd(SETTLE_ADDR, 8'h04);
    @(posedge clk);
    `chk({cpu_reset_out, cpu_clk_en, cpu_resume}, 3'b100)
    nmi_req     <= 1'b0;
    reset_pin_n <= 1'b1;
    t0 = cyc;
    `await(cpu_reset_out === 1'b0, d + 200)
    `chk(1'(cyc - t0 >= d + 64 && cyc - t0 <= d + 110), 1'b1)
    `await(cpu_clk_en === 1'b1, 20)
    `chk(cpu_clk_en, 1'b1)
  endtask : pin_reset

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    {sys_rst, reset_pin_n, cpu_wr_en, cpu_wr_byte, cpu_rd_en} = 5'b11000;
    {halt_exec, stop_exec, global_int_allow_flag, nmi_req, rd_d} = 5'b00000;
    {cpu_addr, cpu_wdata, int_req, source_mask_flag} = 40'h0000_0000_00ff;
    start_dly  = 16'h0004;
    periph_cfg = '0;
    num_errors = 0;
    cmp_count  = 0;
    cyc        = 0;
    void'($urandom(32'h9e32));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    `await(cpu_clk_en === 1'b1, 500)
    `chk({cpu_clk_en, cpu_reset_out}, 2'b10)
    rd(SETTLE_ADDR, 8'h04);
    for (int c = 0; c < 8; c++) begin
      wr(SETTLE_ADDR, {5'($urandom), 3'(c)}, 1'b1);
      rd(SETTLE_ADDR, {5'h00, 3'(c)});
    end
    wr(SETTLE_ADDR, 8'h02, 1'b0);
    wr(16'hfff9, 8'h01, 1'b1);
    rd(SETTLE_ADDR, 8'h07);
    rd(16'hfff9, 8'h00);
    halt_wake(1'b1, 1'b0);
    halt_wake(1'b0, 1'b0);
    halt_wake(1'b0, 1'b1);
    stop_wake(3'h0, 1'b0);
    stop_wake(3'h2, 1'b0);
    stop_wake(3'h4, 1'b0);
    stop_wake(3'h2, 1'b1);
    pin_reset(1'b0, 4);
    pin_reset(1'b1, 100);
    end_sim();
  end
endmodule : tb_standby_halt_stop_control
